// ### pcsig_pkg.sv
package pcsig_pkg;

	// Socket interface modes
	typedef enum logic [1:0] {
		PCSIG_MODE_MEM,
		PCSIG_MODE_IO,
		PCSIG_MODE_CARDBUS,
		PCSIG_MODE_ATA
	} pcsig_mode_t;

	// Voltage classes decoded from the sense pins
	typedef enum logic [1:0] {
		PCSIG_VOLT_NONE,
		PCSIG_VOLT_5V,
		PCSIG_VOLT_3V3,
		PCSIG_VOLT_LOW
	} pcsig_volt_t;

	// Host side access request
	typedef struct packed {
		logic access;
		logic eight_bit;
		logic lowest_address_bit;
		logic word;
		logic reset_card;
		logic cb_cad10;
		logic cb_cbe0_n;
	} pcsig_req_t;

	// Interpreted card status
	typedef struct packed {
		logic battery_dead_status;
		logic battery_warning_status;
		logic speaker_audio_in;
		logic drive_led_in;
		logic card_status_changed;
		logic ring_indicate_in;
		logic cb_audio;
		logic cb_status_change;
	} pcsig_stat_t;

	localparam logic [1:0] PCSIG_SYNC_STAGES = 2'h2;
	localparam logic       PCSIG_RST_CE      = 1'h1;
	localparam logic       PCSIG_RST_RESET   = 1'h0;
	localparam logic       PCSIG_RST_RST_OE  = 1'h0;
	localparam pcsig_volt_t PCSIG_RST_VOLT   = PCSIG_VOLT_NONE;
	localparam logic [1:0] PCSIG_RST_PULLUP  = 2'h0;
	localparam logic       PCSIG_RST_PRESENT = 1'h0;
	localparam logic       PCSIG_RST_ATA     = 1'h0;
	// Synchroniser flops start at the pins' pulled-up idle level
	localparam logic [5:0] PCSIG_RST_SYNC    = 6'h3f;

endpackage

// ### pcsig_socket.sv
`timescale 1ns/1ns
// Overview of operation
// (R1) Card enables go low during access; first for even, second for odd bytes.
// (R2) Eight-bit socket uses only first enable; lowest address bit picks byte.
// (R3) Sixteen-bit modes: reset output low normally, high to reset card.
// (R4) Reset pin floats unless card seated, power on and signals enabled.
// (R5) CardBus mode reuses reset pin as active-low card reset.
// (R6) CardBus mode: second enable pin is CAD10, first is CBE0.
// (R7) Second battery pin: warning, speaker input, or drive LED input by mode.
// (R8) First battery pin: battery dead in memory mode, status changed in I/O.
// (R9) Ring enable bit set makes status pin the ring indicate input.
// (R10) CardBus card signals status changes on the status change line.
// (R11) Both voltage sense inputs decide sixteen-bit card operating voltage.
// (R12) Sense pull-ups enabled jointly by data write bits and pull-up bits.
// (R13) CardBus: sense and card-detect inputs decide initial card voltage.
// (R14) ATA drive configuration changes the socket pin functions.
// (R15) Pulled-high card-detect inputs both low mean a card is present.
// (R16) Per-socket mode selects memory, I/O or CardBus routing of pins.
module pcsig_socket
	import pcsig_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Configuration
	input  wire pcsig_mode_t mode,
	input  wire logic        ring_enable,
	input  wire logic        led_select,
	input  wire logic        speaker_enable,
	input  wire logic        card_power_on,
	input  wire logic        interface_enable,
	input  wire logic [1:0]  sense_write_bits,
	input  wire logic [1:0]  sense_pullup_bits,
	// Host request
	input  wire pcsig_req_t  req,
	// Card pins
	input  wire logic [1:0]  card_present_inputs,
	input  wire logic        voltage_sense_first,
	input  wire logic        voltage_sense_second,
	input  wire logic        battery_dead_status_pin,
	input  wire logic        battery_warning_status_pin,
	output logic             card_enable_even,
	output logic             card_enable_odd,
	output logic             card_reset_out,
	output logic             card_reset_oe,
	output logic [1:0]       sense_pullup_en,
	// Status
	output logic             card_present,
	output pcsig_volt_t      card_voltage,
	output pcsig_stat_t      status,
	output logic             ata_pin_map
);

	// Two-stage synchronisers for asynchronous pins
	logic [5:0] s1_q, s2_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= PCSIG_RST_SYNC;
			s2_q <= PCSIG_RST_SYNC;
		end else begin
			s1_q <= {card_present_inputs, voltage_sense_first, voltage_sense_second,
				battery_dead_status_pin, battery_warning_status_pin};
			s2_q <= s1_q;
		end
	end

	logic [1:0] cd_s;
	logic       vs1_s, vs2_s, battery_dead_status_s, battery_warning_status_s;
	assign cd_s   = s2_q[5:4];
	assign vs1_s  = s2_q[3];
	assign vs2_s  = s2_q[2];
	assign battery_dead_status_s = s2_q[1];
	assign battery_warning_status_s = s2_q[0];

	// Voltage decode, shared by both interface families; argument is {cd, vs2, vs1}
	// Any detect pin high gives no voltage class, so a half-seated card stays unpowered
	function automatic pcsig_volt_t volt_decode(input logic [3:0] v);
		pcsig_volt_t r;
		r = PCSIG_VOLT_NONE;
		unique case (v)
			4'h3: r = PCSIG_VOLT_5V;
			4'h2, 4'h1: r = PCSIG_VOLT_3V3;
			4'h0: r = PCSIG_VOLT_LOW;
			default: r = PCSIG_VOLT_NONE;
		endcase
		return r;
	endfunction

	logic        ce_even_d, ce_even_q, ce_odd_d, ce_odd_q;
	logic        rst_d, rst_q, rst_oe_d, rst_oe_q;
	logic [1:0]  pu_d, pu_q;
	logic        present_d, present_q, ata_d, ata_q;
	pcsig_volt_t volt_d, volt_q;
	pcsig_stat_t stat_d, stat_q;
	logic        cb;

	// Next-state logic for all socket pins
	always_comb begin
		cb = (mode == PCSIG_MODE_CARDBUS);
		present_d = (cd_s == 2'h0); // (R15)
		ce_even_d = 1'h1;
		ce_odd_d  = 1'h1;
		if (cb) begin
			ce_even_d = req.cb_cbe0_n; // (R6)
			ce_odd_d  = req.cb_cad10; // (R6)
		end else if (req.access) begin
			if (req.eight_bit) begin
				ce_even_d = 1'h0; // (R2)
			end else if (req.word) begin
				ce_even_d = 1'h0; // (R1)
				ce_odd_d  = 1'h0; // (R1)
			end else begin
				ce_even_d = req.lowest_address_bit; // (R1)
				ce_odd_d  = ~req.lowest_address_bit; // (R1)
			end
		end
		// Floating until safe avoids a glitch while power ramps
		rst_oe_d = present_d && card_power_on && interface_enable; // (R4)
		rst_d = cb ? ~req.reset_card : req.reset_card; // (R3) (R5)
		pu_d = sense_write_bits & sense_pullup_bits; // (R12)
		if (cb) begin
			volt_d = (cd_s == 2'h3) ? PCSIG_VOLT_NONE : volt_decode({cd_s, vs2_s, vs1_s}); // (R13)
		end else begin
			volt_d = present_d ? volt_decode({2'h0, vs2_s, vs1_s}) : PCSIG_VOLT_NONE; // (R11)
		end
		ata_d = (mode == PCSIG_MODE_ATA); // (R14)
		stat_d = '0;
		unique case (mode) // (R16)
			PCSIG_MODE_MEM: begin
				stat_d.battery_dead_status    = battery_dead_status_s; // (R8)
				stat_d.battery_warning_status = battery_warning_status_s; // (R7)
			end
			PCSIG_MODE_IO, PCSIG_MODE_ATA: begin
				stat_d.card_status_changed = ~ring_enable & ~battery_dead_status_s; // (R8)
				stat_d.ring_indicate_in    = ring_enable & ~battery_dead_status_s; // (R9)
				stat_d.drive_led_in        = led_select & ~battery_warning_status_s; // (R7)
				stat_d.speaker_audio_in    = ~led_select & speaker_enable & ~battery_warning_status_s; // (R7)
			end
			PCSIG_MODE_CARDBUS: begin
				stat_d.cb_audio         = battery_warning_status_s;
				stat_d.cb_status_change = battery_dead_status_s; // (R10)
			end
		endcase
	end

	// Registers; all outputs leave straight from flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ce_even_q <= PCSIG_RST_CE;
			ce_odd_q  <= PCSIG_RST_CE;
			rst_q     <= PCSIG_RST_RESET;
			rst_oe_q  <= PCSIG_RST_RST_OE;
			pu_q      <= PCSIG_RST_PULLUP;
			present_q <= PCSIG_RST_PRESENT;
			ata_q     <= PCSIG_RST_ATA;
			volt_q    <= PCSIG_RST_VOLT;
			stat_q    <= '0;
		end else begin
			ce_even_q <= ce_even_d;
			ce_odd_q  <= ce_odd_d;
			rst_q     <= rst_d;
			rst_oe_q  <= rst_oe_d;
			pu_q      <= pu_d;
			present_q <= present_d;
			ata_q     <= ata_d;
			volt_q    <= volt_d;
			stat_q    <= stat_d;
		end
	end

	assign card_enable_even = ce_even_q;
	assign card_enable_odd  = ce_odd_q;
	assign card_reset_out   = rst_q;
	assign card_reset_oe    = rst_oe_q;
	assign sense_pullup_en  = pu_q;
	assign card_present     = present_q;
	assign card_voltage     = volt_q;
	assign status           = stat_q;
	assign ata_pin_map      = ata_q;

	// Checks
	AST_EIGHT_BIT_ODD_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != PCSIG_MODE_CARDBUS && req.access && req.eight_bit) |=> card_enable_odd) // (R2)
		else $error("odd enable active in 8-bit mode");
	AST_EVEN_ODD_SELECT: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != PCSIG_MODE_CARDBUS && req.access && !req.eight_bit && !req.word)
		|=> (card_enable_even == $past(req.lowest_address_bit)) && (card_enable_odd != card_enable_even)) // (R1)
		else $error("byte enable select wrong");
	AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != PCSIG_MODE_CARDBUS && !req.access) |=> card_enable_even && card_enable_odd) // (R1)
		else $error("enable active while idle");
	AST_RESET_FLOAT: assert property (@(posedge clk) disable iff (!reset_n)
		(!card_power_on || !interface_enable) |=> !card_reset_oe) // (R4)
		else $error("reset driven while unsafe");
	AST_RESET_16: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != PCSIG_MODE_CARDBUS) |=> card_reset_out == $past(req.reset_card)) // (R3)
		else $error("16-bit reset polarity");
	AST_RESET_CB: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == PCSIG_MODE_CARDBUS) |=> card_reset_out == !$past(req.reset_card)) // (R5)
		else $error("CardBus reset polarity");
	AST_CB_ENABLES: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == PCSIG_MODE_CARDBUS) |=> card_enable_odd == $past(req.cb_cad10)) // (R6)
		else $error("CardBus CAD10 routing");
	AST_PULLUP: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |=> sense_pullup_en == ($past(sense_write_bits) & $past(sense_pullup_bits))) // (R12)
		else $error("pull-up control wrong");
	AST_PRESENT: assert property (@(posedge clk) disable iff (!reset_n)
		(card_present_inputs == 2'h3) [*3] |=> !card_present) // (R15)
		else $error("card present with detect high");
	AST_RING: assert property (@(posedge clk) disable iff (!reset_n)
		ring_enable && mode == PCSIG_MODE_IO |=> !status.card_status_changed) // (R9)
		else $error("status change seen in ring mode");
	AST_CB_CBE0: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == PCSIG_MODE_CARDBUS) |=> card_enable_even == $past(req.cb_cbe0_n)) // (R6)
		else $error("CardBus CBE0 routing");
	AST_WORD_BOTH: assert property (@(posedge clk) disable iff (!reset_n)
		(mode != PCSIG_MODE_CARDBUS && req.access && !req.eight_bit && req.word)
		|=> !card_enable_even && !card_enable_odd) // (R1)
		else $error("word access missing an enable");
	// Reset drive must never precede card detection
	AST_RESET_NO_CARD: assert property (@(posedge clk) disable iff (!reset_n)
		!card_present |-> !card_reset_oe) // (R4)
		else $error("reset driven with no card");
	AST_ATA_MAP: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == PCSIG_MODE_ATA) |=> ata_pin_map) // (R14)
		else $error("ATA pin map not selected");
	AST_MEM_NO_AUDIO: assert property (@(posedge clk) disable iff (!reset_n)
		(mode == PCSIG_MODE_MEM) |=> !status.speaker_audio_in && !status.drive_led_in) // (R16)
		else $error("I/O status seen in memory mode");
	COV_WORD: cover property (@(posedge clk) req.access && req.word ##1 !card_enable_odd);
	COV_RESET_DRIVEN: cover property (@(posedge clk) card_reset_oe && card_reset_out);
	COV_CB: cover property (@(posedge clk) mode == PCSIG_MODE_CARDBUS ##1 card_present);
	COV_RING: cover property (@(posedge clk) status.ring_indicate_in);

endmodule

// ### pcsig_card_model.sv
`timescale 1ns/1ns
module pcsig_card_model (
	// Scenario control
	input  wire logic       seated,
	input  wire logic [1:0] vs_code,
	input  wire logic [1:0] bvd_lvl,
	// Socket pins
	output logic [1:0]      cd_pins,
	output logic            vs1_pin,
	output logic            vs2_pin,
	output logic            battery_dead_status_pin,
	output logic            battery_warning_status_pin
);
	// Empty socket leaves every pin on its pull-up
	assign cd_pins  = seated ? 2'h0 : 2'h3;
	assign vs1_pin  = seated ? vs_code[0] : 1'h1;
	assign vs2_pin  = seated ? vs_code[1] : 1'h1;
	// Same pin carries status change alerts in CardBus
	assign battery_dead_status_pin = seated ? bvd_lvl[0] : 1'h1;
	assign battery_warning_status_pin = seated ? bvd_lvl[1] : 1'h1;
endmodule

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top
	import pcsig_pkg::*;
;
	logic        clk = 1'h0, reset_n = 1'h0, ring_enable = 1'h0, led_select = 1'h0;
	logic        speaker_enable = 1'h0, card_power_on = 1'h1, interface_enable = 1'h1;
	logic [1:0]  sense_write_bits = 2'h0, sense_pullup_bits = 2'h0;
	logic        seated = 1'h0;
	logic [1:0]  vs_code = 2'h3, bvd_lvl = 2'h3, cdp, pu_en;
	pcsig_mode_t mode = PCSIG_MODE_MEM;
	pcsig_req_t  req = '0;
	logic        vs1, vs2, b1, b2, ce_e, ce_o, rst_o, rst_oe, present, ata;
	pcsig_volt_t volt;
	pcsig_stat_t stat;
	int          bad_count = 0, tests_run = 0;
	// Columns: access, eight_bit, address bit, word, even enable, odd enable
	logic [5:0]  rows [6] = '{6'h03, 6'h24, 6'h21, 6'h2a, 6'h31, 6'h39};

	// 50 ns period
	always #25 clk = ~clk;

	pcsig_card_model CARD (.seated(seated), .vs_code(vs_code), .bvd_lvl(bvd_lvl),
		.cd_pins(cdp), .vs1_pin(vs1), .vs2_pin(vs2), .battery_dead_status_pin(b1), .battery_warning_status_pin(b2));

	pcsig_socket DUT (.clk(clk), .reset_n(reset_n), .mode(mode), .ring_enable(ring_enable),
		.led_select(led_select), .speaker_enable(speaker_enable),
		.card_power_on(card_power_on), .interface_enable(interface_enable),
		.sense_write_bits(sense_write_bits), .sense_pullup_bits(sense_pullup_bits),
		.req(req), .card_present_inputs(cdp), .voltage_sense_first(vs1),
		.voltage_sense_second(vs2), .battery_dead_status_pin(b1), .battery_warning_status_pin(b2),
		.card_enable_even(ce_e), .card_enable_odd(ce_o), .card_reset_out(rst_o),
		.card_reset_oe(rst_oe), .sense_pullup_en(pu_en), .card_present(present),
		.card_voltage(volt), .status(stat), .ata_pin_map(ata));

	task automatic summarize;
		$display("Checks %0d, errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %b want %b", $time, got, exp);
		end
	endtask

	task automatic chkv(input pcsig_volt_t got, input pcsig_volt_t exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: voltage %0d want %0d", $time, got, exp);
		end
	endtask

	// Pins pass a two-flop sync, so wait four edges for them
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Hang guard, far above the expected run of about 60 cycles
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		summarize();
	end

	initial begin
		step(5);
		chk(ce_e, 1'h1);
		chk(rst_oe, 1'h0);
		chk(present, 1'h0);
		@(posedge clk) reset_n <= 1'h1;
		foreach (rows[i]) begin
			@(posedge clk) req <= {rows[i][5:2], 3'h1};
			step(1);
			chk(ce_e, rows[i][1]);
			chk(ce_o, rows[i][0]);
		end
		// Empty socket must float reset though power and signals are on
		step(4);
		chk(rst_oe, 1'h0);
		@(posedge clk) seated <= 1'h1;
		step(4);
		chk(present, 1'h1);
		chk(rst_oe, 1'h1);
		chkv(volt, PCSIG_VOLT_5V);
		@(posedge clk) interface_enable <= 1'h0;
		step(1);
		chk(rst_oe, 1'h0);
		@(posedge clk) interface_enable <= 1'h1;
		req.reset_card <= 1'h1;
		vs_code <= 2'h0;
		step(4);
		chk(rst_o, 1'h1);
		chkv(volt, PCSIG_VOLT_LOW);
		chk(stat.battery_dead_status, 1'h1);
		chk(stat.battery_warning_status, 1'h1);
		@(posedge clk) req.reset_card <= 1'h0;
		step(1);
		chk(rst_o, 1'h0);
		@(posedge clk) mode <= PCSIG_MODE_IO;
		bvd_lvl <= 2'h0;
		speaker_enable <= 1'h1;
		step(4);
		chk(stat.card_status_changed, 1'h1);
		chk(stat.speaker_audio_in, 1'h1);
		@(posedge clk) ring_enable <= 1'h1;
		step(1);
		chk(stat.ring_indicate_in, 1'h1);
		@(posedge clk) led_select <= 1'h1;
		step(1);
		chk(stat.drive_led_in, 1'h1);
		chk(stat.speaker_audio_in, 1'h0);
		@(posedge clk) mode <= PCSIG_MODE_CARDBUS;
		req <= '{reset_card: 1'h1, cb_cbe0_n: 1'h1, default: 1'h0};
		sense_write_bits <= 2'h3;
		sense_pullup_bits <= 2'h3;
		bvd_lvl <= 2'h1;
		vs_code <= 2'h3;
		step(1);
		chk(rst_o, 1'h0);
		chk(ce_o, 1'h0);
		chk(ce_e, 1'h1);
		chk(pu_en[0], 1'h1);
		chk(pu_en[1], 1'h1);
		step(3);
		chk(stat.cb_status_change, 1'h1);
		chk(stat.cb_audio, 1'h0);
		chkv(volt, PCSIG_VOLT_5V);
		@(posedge clk) seated <= 1'h0;
		step(4);
		chkv(volt, PCSIG_VOLT_NONE);
		@(posedge clk) mode <= PCSIG_MODE_ATA;
		step(1);
		chk(ata, 1'h1);
		@(posedge clk) reset_n <= 1'h0;
		step(1);
		chk(ce_e, 1'h1);
		chk(pu_en[0], 1'h0);
		summarize();
	end
endmodule
